// ==== core/sram_ctl_map.svh ====
`ifndef SRAM_CTL_MAP_SVH
`define SRAM_CTL_MAP_SVH

// ****************************************
// timing figures and derived cycle counts
// ****************************************
`define CLK_PERIOD_NS         40
`define POWER_UP_WAIT_US      100
`define POWER_UP_WAIT_CYC     ((`POWER_UP_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDRESS_ACCESS_NS     12
`define READ_CYC              ((`ADDRESS_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_PULSE_NS           12
`define WE_PULSE_CYC          ((`WE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_DATA_SETUP_NS   6
`define DATA_SETUP_CYC        ((`WRITE_DATA_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W                16
`define DATA_W                16
`define CNT_W                 12

`endif

// ==== core/sram_ctl_pkg.sv ====
`default_nettype none
package sram_ctl_pkg;
	typedef enum logic [4:0] {
		ST_POWER = 5'b00001,
		ST_IDLE  = 5'b00010,
		ST_READ  = 5'b00100,
		ST_SETUP = 5'b01000,
		ST_WRITE = 5'b10000
	} ctl_state_t;
endpackage
`default_nettype wire

// ==== core/sram_host_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctl_map.svh"

module sram_host_ctl
	import sram_ctl_pkg::*;
#(
	parameter int unsigned POWER_UP_WAIT_CYC = `POWER_UP_WAIT_CYC
) (
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire logic                 req_write,
	input  wire logic [`ADDR_W-1:0]   req_addr,
	input  wire logic [`DATA_W-1:0]   req_wdata,
	input  wire logic [1:0]           req_byte_en,
	output logic                      rsp_valid,
	output logic [`DATA_W-1:0]        rsp_rdata,
	output logic [`ADDR_W-1:0]        mem_addr,
	output logic                      chip_select_n,
	output logic                      write_strobe_n,
	output logic                      output_gate_n,
	output logic                      low_byte_select_n,
	output logic                      high_byte_select_n,
	input  wire logic [`DATA_W-1:0]   mem_data_in,
	output logic [`DATA_W-1:0]        mem_data_out,
	output logic                      mem_data_oe_n
);

	// ****************************************
	// reset release
	// ****************************************
	logic       rst_meta;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	ctl_state_t              state;
	logic [16:0]             pwr_cnt;
	logic [`CNT_W-1:0]       cnt;

	function automatic logic [`CNT_W-1:0] cyc(input int unsigned n);
		cyc = (n < 1) ? `CNT_W'(1) : `CNT_W'(n);
	endfunction

	// an empty lane mask is not a request at all
	function automatic logic is_start(input logic v, input logic [1:0] be);
		is_start = v && (be != 2'b00);
	endfunction

	assign req_ready = (state == ST_IDLE);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state   <= ST_POWER;
			pwr_cnt <= 17'h00000;
			cnt     <= 12'h000;
		end else begin
			case (state)
				ST_POWER: begin
					// first access only after the supply has settled
					if (pwr_cnt >= 17'(POWER_UP_WAIT_CYC - 1)) begin
						state <= ST_IDLE;
					end
					pwr_cnt <= pwr_cnt + 17'h00001;
				end
				ST_IDLE: begin
					if (is_start(req_valid, req_byte_en)) begin
						if (req_write) begin
							state <= ST_SETUP;
							cnt   <= 12'h000;
						end else begin
							state <= ST_READ;
							cnt   <= cyc(`READ_CYC) - 12'h001;
						end
					end
				end
				ST_READ: begin
					if (cnt == 12'h000) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 12'h001;
					end
				end
				ST_SETUP: begin
					// strobe low for the sum of width and setup
					state <= ST_WRITE;
					cnt   <= cyc(`WE_PULSE_CYC + `DATA_SETUP_CYC) - 12'h001;
				end
				ST_WRITE: begin
					if (cnt == 12'h000) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 12'h001;
					end
				end
				default: state <= ST_POWER;
			endcase
		end
	end

	// ****************************************
	// memory pins
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr           <= 16'h0000;
			chip_select_n      <= 1'b1;
			output_gate_n      <= 1'b1;
			write_strobe_n     <= 1'b1;
			low_byte_select_n  <= 1'b1;
			high_byte_select_n <= 1'b1;
			mem_data_out       <= 16'h0000;
			mem_data_oe_n      <= 1'b1;
		end else begin
			case (state)
				ST_IDLE: begin
					if (is_start(req_valid, req_byte_en)) begin
						// address and select together, selects ahead of the strobe
						mem_addr           <= req_addr;
						chip_select_n      <= 1'b0;
						low_byte_select_n  <= ~req_byte_en[0];
						high_byte_select_n <= ~req_byte_en[1];
						output_gate_n      <= req_write;
						mem_data_out       <= req_wdata;
						mem_data_oe_n      <= ~req_write;
					end
				end
				ST_SETUP: write_strobe_n <= 1'b0;
				ST_READ: begin
					if (cnt == 12'h000) begin
						chip_select_n      <= 1'b1;
						output_gate_n      <= 1'b1;
						low_byte_select_n  <= 1'b1;
						high_byte_select_n <= 1'b1;
					end
				end
				ST_WRITE: begin
					if (cnt == 12'h000) begin
						// strobe ends the write first; others follow a cycle later
						write_strobe_n <= 1'b1;
					end
				end
				default: begin
					chip_select_n      <= 1'b1;
					output_gate_n      <= 1'b1;
					low_byte_select_n  <= 1'b1;
					high_byte_select_n <= 1'b1;
					mem_data_oe_n      <= 1'b1;
				end
			endcase
			if (state == ST_IDLE && !is_start(req_valid, req_byte_en)) begin
				chip_select_n      <= 1'b1;
				low_byte_select_n  <= 1'b1;
				high_byte_select_n <= 1'b1;
				mem_data_oe_n      <= 1'b1;
			end
		end
	end

	// ****************************************
	// read return
	// ****************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
		end else begin
			rsp_valid <= 1'b0;
			if (state == ST_READ && cnt == 12'h000) begin
				rsp_valid <= 1'b1;
				rsp_rdata <= mem_data_in;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_strobe_needs_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!write_strobe_n |-> !chip_select_n && (!low_byte_select_n || !high_byte_select_n))
		else $error("write strobe without full select");
	chk_no_drive_on_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!output_gate_n |-> mem_data_oe_n)
		else $error("data driven while output gate low");
	chk_power_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state == ST_POWER |-> chip_select_n)
		else $error("access during power-up wait");
	// width and setup each round up to one cycle; the strobe covers both, two cycles
	sequence strobe_low_run;
		!write_strobe_n [*2];
	endsequence
	sequence strobe_back_high;
		write_strobe_n;
	endsequence
	chk_strobe_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(write_strobe_n) |-> strobe_low_run ##1 strobe_back_high)
		else $error("write strobe not two cycles low");
	chk_addr_stable_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!write_strobe_n |-> $stable(mem_addr) && !chip_select_n)
		else $error("address moved during write");
	chk_data_stable_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!write_strobe_n |-> !mem_data_oe_n && $stable(mem_data_out))
		else $error("write data moved during strobe");
	chk_read_response: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == ST_IDLE && req_valid && !req_write && req_byte_en != 2'b00)
		|-> ##1 !rsp_valid ##1 rsp_valid)
		else $error("read response not on time");
	chk_release_after_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(write_strobe_n) |-> !mem_data_oe_n && !chip_select_n ##1 state != ST_WRITE)
		else $error("data released before write end");

endmodule

`default_nettype wire

// ==== testbench/sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// word memory with byte lanes
// ****
module sram_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] mem_addr,
	input  wire logic        chip_select_n,
	input  wire logic        write_strobe_n,
	input  wire logic        output_gate_n,
	input  wire logic        low_byte_select_n,
	input  wire logic        high_byte_select_n,
	input  wire logic [15:0] host_data,
	input  wire logic        host_oe_n,
	output logic      [15:0] pins
);
	logic [15:0] mem [0:65535];
	logic [15:0] junk = 16'h5A5A;
	logic        rd;
	logic        lo;
	logic        hi;
	// stored at the end of the overlap, where setup is measured
	always @(posedge write_strobe_n) begin
		if (!chip_select_n && !low_byte_select_n) mem[mem_addr][7:0] = host_data[7:0];
		if (!chip_select_n && !high_byte_select_n) mem[mem_addr][15:8] = host_data[15:8];
	end
	// released lanes move every cycle so a stale value never looks valid
	always @(posedge clk_sys) junk <= ~junk;
	assign rd = !chip_select_n && write_strobe_n && !output_gate_n;
	assign lo = rd && !low_byte_select_n;
	assign hi = rd && !high_byte_select_n;
	// zero-delay data path: access and hold limits are met with margin
	assign pins = {(!host_oe_n ? host_data[15:8] : hi ? mem[mem_addr][15:8] : junk[15:8]),
		(!host_oe_n ? host_data[7:0] : lo ? mem[mem_addr][7:0] : junk[7:0])};
endmodule
`default_nettype wire

// ==== testbench/test_sram_host_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_sram_host_ctl;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        req_valid = 1'b0;
	logic        req_write = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0]  req_byte_en = 2'h0;
	logic        req_ready, rsp_valid, cs_n, we_n, oe_n, lb_n, hb_n, d_oe_n;
	logic [15:0] rsp_rdata, a, d_out, pins;
	int          n_fail = 0;
	int          checked = 0;
	int          lo = 0;
	int          k;
	// ****
	// write, read, rmw of lanes, top address
	// ****
	localparam logic [50:0] ROWS [9] = '{
		{1'h1, 16'h0001, 16'hFFFF, 2'h3, 16'h0000},
		{1'h1, 16'h0001, 16'h1234, 2'h1, 16'h0000},
		{1'h0, 16'h0001, 16'h0000, 2'h3, 16'hFF34},
		{1'h1, 16'h0001, 16'hABCD, 2'h2, 16'h0000},
		{1'h0, 16'h0001, 16'h0000, 2'h1, 16'h0034},
		{1'h0, 16'h0001, 16'h0000, 2'h2, 16'hAB00},
		{1'h1, 16'hFFFF, 16'h8001, 2'h3, 16'h0000},
		{1'h0, 16'hFFFF, 16'h0000, 2'h3, 16'h8001},
		{1'h0, 16'h0001, 16'h0000, 2'h3, 16'hAB34}};
	sram_host_ctl #(.POWER_UP_WAIT_CYC(4)) u_sram_host_ctl (.clk_sys(clk_sys), .resetn(resetn),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_byte_en(req_byte_en), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .mem_addr(a), .chip_select_n(cs_n), .write_strobe_n(we_n),
		.output_gate_n(oe_n), .low_byte_select_n(lb_n), .high_byte_select_n(hb_n),
		.mem_data_in(pins), .mem_data_out(d_out), .mem_data_oe_n(d_oe_n));
	sram_model u_sram_model (.clk_sys(clk_sys), .mem_addr(a), .chip_select_n(cs_n),
		.write_strobe_n(we_n), .output_gate_n(oe_n), .low_byte_select_n(lb_n),
		.high_byte_select_n(hb_n), .host_data(d_out), .host_oe_n(d_oe_n), .pins(pins));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wait_hi(input bit rsp);
		int i;
		for (i = 0; i < 20 && (rsp ? rsp_valid : req_ready) !== 1'b1; i++) @(negedge clk_sys);
		if (i == 20) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic op(input logic [50:0] r);
		logic [15:0] m;
		m = {{8{r[17]}}, {8{r[16]}}};
		wait_hi(1'b0);
		@(posedge clk_sys);
		{req_write, req_addr, req_wdata, req_byte_en} <= r[50:16];
		req_valid <= 1'b1;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(negedge clk_sys);
		if (!r[50]) begin
			wait_hi(1'b1);
			chk("rdata", rsp_rdata & m, r[15:0] & m);
		end
	endtask
	// strobe width and pin ownership seen on every cycle of a write
	always @(negedge clk_sys) begin
		if (!oe_n) chk("oe_rd", d_oe_n, 1);
		if (we_n === 1'b0) begin
			lo++;
			chk("cs_wr", {lb_n & hb_n, cs_n}, 0);
			chk("oe_wr", d_oe_n, 0);
		end else if (lo != 0) begin
			chk("we_len", lo == 2, 1);
			chk("cs_end", cs_n, 0);
			lo = 0;
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		chk("rdy_rst", req_ready, 0);
		chk("cs_rst", cs_n, 1);
		resetn <= 1'b1;
		for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge clk_sys);
		chk("pwr", k >= 4 && k < 20, 1);
		if (k == 20) stop_test();
		foreach (ROWS[i]) op(ROWS[i]);
		// empty lane mask must start nothing
		@(posedge clk_sys);
		req_byte_en <= 2'h0;
		req_valid <= 1'b1;
		repeat (4) begin
			@(negedge clk_sys);
			chk("be0", cs_n, 1);
		end
		@(posedge clk_sys);
		req_valid <= 1'b0;
		// reset lands in the middle of a write
		op({1'h1, 16'h0002, 16'h5555, 2'h3, 16'h0000});
		@(posedge clk_sys);
		resetn <= 1'b0;
		@(negedge clk_sys);
		chk("mid", {req_ready, we_n, cs_n}, 3);
		@(posedge clk_sys);
		resetn <= 1'b1;
		op(ROWS[7]);
		stop_test();
	end
endmodule
`default_nettype wire
